// ===== src/cspsw_pkg.sv
// Package for the cyclic synchronous position status word block.
// Assumes a single 40 MHz clock domain and an Avalon-MM register slave.
package cspsw_pkg;

  // ***************************************************************
  // Status word and control word bit positions
  // ***************************************************************
  localparam int SW_TORQUE     = 15;
  localparam int SW_FOLLOW     = 13;
  localparam int SW_ACCEPT     = 12;
  localparam int SW_ILIMIT     = 11;
  localparam int SW_REMOTE     = 9;
  localparam int SW_WARN       = 7;
  localparam int SW_VOLTAGE    = 4;
  localparam int CTRL_HALT     = 8;

  // ***************************************************************
  // Register map (byte addresses, word aligned)
  // ***************************************************************
  localparam logic [3:0] ADDR_STATUS_WORD  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_WORD = 4'h4;
  localparam logic [3:0] ADDR_FOLLOW_WIN   = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS   = 4'hc;
  localparam logic [3:0] ADDR_IRQ_ENABLE   = 4'h0; // unused alias guard, see decode
  localparam logic [5:0] ADDR6_IRQ_ENABLE  = 6'h10;
  localparam logic [5:0] ADDR6_IRQ_CLEAR   = 6'h14;

  // ***************************************************************
  // Reset values and alarm codes
  // ***************************************************************
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [31:0] FOLLOW_WIN_RESET = 32'h0000_ffff;
  localparam logic [7:0]  ALARM_DEVIATION  = 8'h10;
  localparam logic [7:0]  ALARM_OVERLOAD   = 8'h30;
  localparam int          IRQ_BITS         = 4;

  // Interrupt sources
  localparam int IRQ_FOLLOW = 0;
  localparam int IRQ_ACCEPT_LOST = 1;
  localparam int IRQ_ILIMIT = 2;
  localparam int IRQ_WARN = 3;

  typedef enum logic [0:0] {
    CSPSW_IDLE = 1'b0,
    CSPSW_RESP = 1'b1
  } cspsw_bus_e;

  typedef struct packed {
    logic fwd_sensor;
    logic rev_sensor;
    logic fwd_prohibit;
    logic rev_prohibit;
    logic soft_limit;
    logic mech_limit;
  } cspsw_limits_s;

  typedef struct packed {
    cspsw_bus_e           bus;
    logic [31:0]          readdata;
    logic [15:0]          control_word;
    logic [31:0]          follow_win;
    logic                 follow_err;
    logic                 remote;
    logic [IRQ_BITS-1:0]  irq_status;
    logic [IRQ_BITS-1:0]  irq_enable;
    logic [15:0]          status_word;
    logic                 accept;
  } cspsw_state_s;

endpackage

// ===== src/cspsw_status_word.sv
// Status word logic for cyclic synchronous position mode, with register slave.
// Assumes all inputs are synchronous to mclk and the master obeys Avalon-MM.
//
// Operation
// R1 - Bit 15 follows the torque-limit input: 1 while the load sits at peak torque.
// R2 - Bit 13 sets when the absolute position deviation exceeds the following window.
// R3 - Bit 13 clears only on reset of a deviation (10h) or overload (30h) alarm.
// R4 - Bit 12 is 0 and targets are dropped when not enabled, unexcited, halted, stopped or limited.
// R5 - Bit 12 is 1 and targets are accepted when no disabling condition holds.
// R6 - Bit 11 is 1 while any sensor, prohibit, software or mechanism limit is active.
// R7 - Bit 9 becomes 1 once initialization has completed.
// R8 - Bit 7 follows the warning condition and needs no acknowledge.
// R9 - Bit 4 is 1 while main power is supplied, whatever the state.
// R10 - Control word bit 8 halts motion at once; writing 0 allows operation again.
// R11 - Bits 14, 10 and 8 read 0 and bits 6, 5 and 3 to 0 carry the state machine code.
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module cspsw_status_word #(
  parameter int POS_W = 32
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    torque_limit_flag,
  input  wire logic [POS_W-1:0]        position_deviation,
  input  wire logic                    alarm_reset,
  input  wire logic [7:0]              alarm_code,
  input  wire logic                    op_enabled,
  input  wire logic                    motor_excited,
  input  wire logic                    stop_input,
  input  wire cspsw_pkg::cspsw_limits_s limits,
  input  wire logic                    init_done,
  input  wire logic                    warning_active,
  input  wire logic                    main_power,
  input  wire logic [6:0]              state_code,
  input  wire logic                    target_valid,
  input  wire logic [POS_W-1:0]        target_in,
  output logic                         target_accept,
  output logic [POS_W-1:0]             target_out,
  output logic                         halt_motion,
  output logic [15:0]                  drive_status_word,
  output logic                         irq
);
  import cspsw_pkg::*;

  initial begin
    if (POS_W < 2 || POS_W > 32) begin
      $error("POS_W must be 2..32");
    end
  end

  // ***************************************************************
  // State
  // ***************************************************************
  cspsw_state_s             st;
  cspsw_state_s             next_st;
  logic [POS_W-1:0]         target_q;
  logic [POS_W-1:0]         next_target_q;
  logic                     target_vq;
  logic                     next_target_vq;

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [POS_W-1:0] abs_dev(input logic [POS_W-1:0] d);
    return d[POS_W-1] ? POS_W'(-d) : d;
  endfunction

  // Addresses that return data; the clear register is write-only and reads 0
  function automatic logic reg_readable(input logic [5:0] a);
    return a == 6'h00 || a == 6'h04 || a == 6'h08 || a == 6'h0c || a == ADDR6_IRQ_ENABLE;
  endfunction

  logic       internal_limit;
  logic       disabled;
  logic       dev_over;
  logic       follow_clear;
  logic [3:0] events;
  logic       hit;
  logic [31:0] ctrl_m;

  // ***************************************************************
  // Combinational next state
  // ***************************************************************
  always_comb begin
    next_st = st;
    next_target_q = target_q;
    next_target_vq = 1'b0;
    internal_limit = |limits; // see R6
    // Halt takes effect from the control word register directly; see R10
    disabled = !op_enabled || !motor_excited || st.control_word[CTRL_HALT]
               || stop_input || internal_limit; // see R4
    dev_over = 32'(abs_dev(position_deviation)) > st.follow_win; // see R2
    follow_clear = alarm_reset && (alarm_code == ALARM_DEVIATION || alarm_code == ALARM_OVERLOAD); // see R3
    // Set wins over clear so a fresh deviation is never lost
    if (follow_clear) begin
      next_st.follow_err = 1'b0; // see R3
    end
    if (dev_over) begin
      next_st.follow_err = 1'b1; // see R2
    end
    if (init_done) begin
      next_st.remote = 1'b1; // see R7
    end
    next_st.accept = !disabled; // see R5
    // Targets are latched only when accepted, otherwise discarded
    if (target_valid && !disabled) begin
      next_target_q = target_in; // see R5
      next_target_vq = 1'b1;
    end
    next_st.status_word = 16'h0000; // see R11
    next_st.status_word[SW_TORQUE] = torque_limit_flag; // see R1
    next_st.status_word[SW_FOLLOW] = next_st.follow_err;
    next_st.status_word[SW_ACCEPT] = !disabled; // see R4
    next_st.status_word[SW_ILIMIT] = internal_limit; // see R6
    next_st.status_word[SW_REMOTE] = next_st.remote;
    next_st.status_word[SW_WARN] = warning_active; // see R8
    next_st.status_word[6:0] = state_code; // see R11
    next_st.status_word[SW_VOLTAGE] = main_power; // see R9

    events = '0;
    events[IRQ_FOLLOW] = dev_over && !st.follow_err;
    events[IRQ_ACCEPT_LOST] = disabled && st.accept;
    events[IRQ_ILIMIT] = internal_limit && !st.status_word[SW_ILIMIT];
    events[IRQ_WARN] = warning_active && !st.status_word[SW_WARN];

    // Register slave: one wait cycle on every access. A write lands only at the answering
    // edge, where the master sees waitrequest low, so a stretched request never writes twice
    hit = reg_readable(avs_address);
    ctrl_m = merge_be({16'h0000, st.control_word}, avs_writedata, avs_byteenable);
    unique case (st.bus)
      CSPSW_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.bus = CSPSW_RESP;
          next_st.readdata = 32'h0000_0000;
          unique case (avs_address)
            6'h00: next_st.readdata = {16'h0000, st.status_word};
            6'h04: next_st.readdata = {16'h0000, st.control_word};
            6'h08: next_st.readdata = st.follow_win;
            6'h0c: next_st.readdata = {{(32-IRQ_BITS){1'b0}}, st.irq_status};
            ADDR6_IRQ_ENABLE: next_st.readdata = {{(32-IRQ_BITS){1'b0}}, st.irq_enable};
            default: next_st.readdata = 32'h0000_0000;
          endcase
        end
      end
      CSPSW_RESP: begin
        next_st.bus = CSPSW_IDLE;
        if (avs_write) begin
          unique case (avs_address)
            6'h04: next_st.control_word = ctrl_m[15:0]; // see R10
            6'h08: next_st.follow_win = merge_be(st.follow_win, avs_writedata, avs_byteenable);
            ADDR6_IRQ_ENABLE: next_st.irq_enable = avs_writedata[IRQ_BITS-1:0];
            ADDR6_IRQ_CLEAR: next_st.irq_status = st.irq_status & ~avs_writedata[IRQ_BITS-1:0];
            default: next_st.bus = CSPSW_IDLE;
          endcase
        end
      end
    endcase
    next_st.irq_status = next_st.irq_status | events;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{bus: CSPSW_IDLE, readdata: 32'h0000_0000, control_word: CTRL_RESET,
              follow_win: FOLLOW_WIN_RESET, follow_err: 1'b0, remote: 1'b0,
              irq_status: '0, irq_enable: '0, status_word: 16'h0000, accept: 1'b0};
      target_q <= '0;
      target_vq <= 1'b0;
    end else begin
      st <= next_st;
      target_q <= next_target_q;
      target_vq <= next_target_vq;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && st.bus == CSPSW_IDLE;
  assign avs_readdata = st.readdata;
  assign drive_status_word = st.status_word;
  assign halt_motion = st.control_word[CTRL_HALT]; // see R10
  assign target_out = target_q;
  assign target_accept = target_vq;
  assign irq = |(st.irq_status & st.irq_enable);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ***************************************************************
  // Status word bits
  // ***************************************************************
  a_torque_bit_follow: assert property (##1 drive_status_word[15] == $past(torque_limit_flag)) // see R1
    else $error("torque bit does not follow input");

  a_follow_sets: assert property (dev_over |=> drive_status_word[13]) // see R2
    else $error("following error not set");

  a_follow_holds: assert property (st.follow_err && !follow_clear |=> st.follow_err) // see R3
    else $error("following error cleared without alarm reset");

  a_follow_clears: assert property (follow_clear && !dev_over |=> !drive_status_word[13]) // see R3
    else $error("following error kept after alarm reset");

  a_accept_blocked: assert property ((stop_input || !motor_excited) |=> !drive_status_word[12] && !target_accept) // see R4
    else $error("target accepted while disabled");

  a_target_dropped: assert property (disabled |=> !target_accept) // see R4
    else $error("target taken while disabled");

  a_accept_open: assert property (!disabled |=> drive_status_word[12]) // see R5
    else $error("accept bit low while enabled");

  a_target_taken: assert property (target_valid && !disabled
                                   |=> target_accept && target_out == $past(target_in)) // see R5
    else $error("offered target not taken");

  a_limit_bit: assert property (internal_limit |=> drive_status_word[11]) // see R6
    else $error("limit bit not set");

  a_limit_clear: assert property (!internal_limit |=> !drive_status_word[11]) // see R6
    else $error("limit bit set without a limit");

  a_remote_sticky: assert property (init_done |=> drive_status_word[9] ##1 drive_status_word[9]) // see R7
    else $error("remote bit not held");

  a_remote_kept: assert property (st.remote |=> drive_status_word[9]) // see R7
    else $error("remote bit dropped");

  a_warn_auto: assert property (!warning_active |=> !drive_status_word[7]) // see R8
    else $error("warning not cleared");

  a_warn_set: assert property (warning_active |=> drive_status_word[7]) // see R8
    else $error("warning not shown");

  a_voltage_bit: assert property (##1 drive_status_word[4] == $past(main_power)) // see R9
    else $error("voltage bit wrong");

  a_halt_blocks: assert property (halt_motion |=> !drive_status_word[12]) // see R10
    else $error("halt did not block targets");

  a_halt_write: assert property (st.bus == CSPSW_RESP && avs_write && avs_address == 6'h04 && avs_byteenable[1]
                                 |=> halt_motion == $past(avs_writedata[CTRL_HALT])) // see R10
    else $error("halt bit not written");

  a_zero_bits: assert property (drive_status_word[14] == 1'b0 && drive_status_word[10] == 1'b0
                                && drive_status_word[8] == 1'b0) // see R11
    else $error("reserved bit set");

  a_state_code: assert property (##1 drive_status_word[6:5] == $past(state_code[6:5])
                                 && drive_status_word[3:0] == $past(state_code[3:0])) // see R11
    else $error("state code bits wrong");

  // ***************************************************************
  // Register slave
  // ***************************************************************
  a_wait_first: assert property ((avs_read || avs_write) && st.bus == CSPSW_IDLE |-> avs_waitrequest)
    else $error("request answered without a wait cycle");

  a_wait_single: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");

  // Writes must not land while the master still sees waitrequest high
  a_write_waits: assert property (avs_waitrequest
                                  |=> $stable(st.control_word) && $stable(st.follow_win) && $stable(st.irq_enable))
    else $error("register written during wait cycle");

  a_window_write: assert property (st.bus == CSPSW_RESP && avs_write && avs_address == 6'h08 && avs_byteenable == 4'hf
                                   |=> st.follow_win == $past(avs_writedata))
    else $error("window write lost");

  a_unmapped_zero: assert property (st.bus == CSPSW_IDLE && avs_read && !hit |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_read_held: assert property (st.bus == CSPSW_IDLE && !avs_read && !avs_write |=> $stable(avs_readdata))
    else $error("read data changed between accesses");

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  a_event_latched: assert property (|events |=> (st.irq_status & $past(events)) == $past(events))
    else $error("event not latched");

  a_enable_write: assert property (st.bus == CSPSW_RESP && avs_write && avs_address == ADDR6_IRQ_ENABLE
                                   |=> st.irq_enable == $past(avs_writedata[IRQ_BITS-1:0]))
    else $error("enable write lost");

  a_irq_cleared: assert property (st.bus == CSPSW_RESP && avs_write && avs_address == ADDR6_IRQ_CLEAR && events == 4'h0
                                  |=> (st.irq_status & $past(avs_writedata[IRQ_BITS-1:0])) == {IRQ_BITS{1'b0}})
    else $error("status bit not cleared");

  // ***************************************************************
  // Covers
  // ***************************************************************
  c_target_taken: cover property (target_valid && !disabled ##1 target_accept);
  c_follow_cycle: cover property (st.follow_err ##[1:20] !st.follow_err);
  c_irq_raised: cover property (!irq ##1 irq);
  c_halt_applied: cover property (!halt_motion ##1 halt_motion);
  c_bus_write: cover property (avs_write && !avs_waitrequest);
endmodule

// ===== sim/cspsw_fieldbus_model.sv
// Fieldbus master model: offers target positions and tallies the ones taken.
// Assumes the block answers an offered target on the following clock edge.
`timescale 1ns/1ps
module cspsw_fieldbus_model (
  input  wire logic        mclk,
  input  wire logic        send,
  input  wire logic [31:0] value,
  output logic             target_valid,
  output logic [31:0]      target_in,
  input  wire logic        target_accept,
  input  wire logic [31:0] target_out,
  output int               n_taken,
  output logic [31:0]      last_taken
);
  initial begin
    target_valid = 1'b0;
    target_in    = 32'h0;
    n_taken      = 0;
    last_taken   = 32'h0;
  end
  // ***************************************************************
  // Offer and capture
  // ***************************************************************
  // Outside an offer the data lines toggle, so stale values are never mistaken for a target
  always @(posedge mclk) begin
    target_valid <= send;
    target_in    <= send ? value : ~target_in;
    if (target_accept === 1'b1) begin
      n_taken    <= n_taken + 1;
      last_taken <= target_out;
    end
  end
endmodule

// ===== sim/test_csp_status_word.sv
// Self-checking bench for the status word block and its register slave.
// Assumes the block answers each bus request after one wait cycle.
`timescale 1ns/1ps
module test_csp_status_word;
  import cspsw_pkg::*;
  logic mclk, sys_rst, rd, wr, tq, al_rst, opn, exc, stp, ini, warn, pwr, send, fe, rem, halt_c;
  logic [5:0] adr;
  logic [31:0] wd, rdat, dev, tval, ltk, rdata, tin, tout;
  logic [3:0] be;
  logic [7:0] acode;
  logic [6:0] sc;
  logic [15:0] sw;
  logic tvalid, tacc, halt, irq, wreq;
  cspsw_limits_s lim;
  int n_fail, checks_done, ntk;
  logic [7:0] codes [3] = '{8'h20, 8'h10, 8'h30};

  cspsw_status_word #(.POS_W(32)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .torque_limit_flag(tq), .position_deviation(dev), .alarm_reset(al_rst), .alarm_code(acode),
    .op_enabled(opn), .motor_excited(exc), .stop_input(stp), .limits(lim), .init_done(ini),
    .warning_active(warn), .main_power(pwr), .state_code(sc), .target_valid(tvalid), .target_in(tin),
    .target_accept(tacc), .target_out(tout), .halt_motion(halt), .drive_status_word(sw), .irq(irq));
  cspsw_fieldbus_model i_master (.mclk(mclk), .send(send), .value(tval), .target_valid(tvalid),
    .target_in(tin), .target_accept(tacc), .target_out(tout), .n_taken(ntk), .last_taken(ltk));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  function automatic logic [15:0] exp_sw();
    logic l;
    l = |lim;
    return {tq, 1'b0, fe, opn & exc & ~halt_c & ~stp & ~l, l, 1'b0, rem, 1'b0, warn, sc[6:5], pwr, sc[3:0]};
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) cmp("waitrequest", 32'h0, {31'h0, wreq});
    rdat = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  // Two edges allowed so a registered flag feeding the word is settled too
  task automatic sw_chk();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    cmp("status word", {16'h0, exp_sw()}, {16'h0, sw});
  endtask
  task automatic offer();
    @(posedge mclk); send <= 1'b1; tval <= tval + 32'h11;
    @(posedge mclk); send <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ***************************************************************
  // Clock, watchdog and tests
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {rd, wr, tq, al_rst, opn, exc, stp, ini, warn, pwr, send, fe, rem, halt_c} = '0;
    adr = '0; wd = '0; dev = '0; tval = 32'h1234_5678; be = 4'hf; acode = '0; sc = '0; lim = '0;
    n_fail = 0; checks_done = 0; sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk); cmp("reset word", 32'h0, {16'h0, sw});
    bus(0, 6'h08, 0); cmp("window reset", 32'h0000_ffff, rdat);
    bus(0, 6'h04, 0); cmp("control reset", 32'h0, rdat);
    bus(0, 6'h3c, 0); cmp("unmapped read", 32'h0, rdat);
    @(posedge mclk); pwr <= 1; ini <= 1; rem <= 1; sc <= 7'h6f; opn <= 1; exc <= 1;
    sw_chk();
    @(posedge mclk); ini <= 0; tq <= 1; warn <= 1;
    sw_chk();
    @(posedge mclk); tq <= 0; warn <= 0;
    sw_chk();
    offer(); repeat (3) @(posedge mclk);
    cmp("targets taken", 32'h1, 32'(ntk));
    cmp("target value", tval, ltk);
    // Each disabling cause except halt alone, offering a target under it
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk); lim <= (i < 6) ? cspsw_limits_s'(6'h20 >> i) : '0; stp <= i == 6; exc <= i != 7; opn <= i != 8;
      sw_chk();
      offer();
    end
    bus(1, 6'h04, 32'h100); halt_c = 1;
    @(posedge mclk); lim <= '0; stp <= 0; exc <= 1; opn <= 1;
    sw_chk();
    cmp("halt motion", 32'h1, {31'h0, halt});
    offer(); repeat (3) @(posedge mclk);
    cmp("targets dropped", 32'h1, 32'(ntk));
    bus(1, 6'h04, 32'h0); halt_c = 0;
    sw_chk();
    cmp("halt released", 32'h0, {31'h0, halt});
    bus(1, 6'h08, 32'h10);
    @(posedge mclk); dev <= 32'h10;
    sw_chk();
    @(posedge mclk); dev <= -32'sd17; fe <= 1;
    sw_chk();
    @(posedge mclk); dev <= 32'h0;
    sw_chk();
    foreach (codes[i]) begin
      @(posedge mclk); dev <= 32'h11; fe <= 1;
      @(posedge mclk); dev <= 32'h0;
      @(posedge mclk); acode <= codes[i]; al_rst <= 1;
      @(posedge mclk); al_rst <= 0; fe <= codes[i] == 8'h20;
      sw_chk();
    end
    bus(0, 6'h00, 0); cmp("word over bus", {16'h0, exp_sw()}, rdat);
    bus(1, 6'h10, 32'h8);
    @(posedge mclk); warn <= 1;
    sw_chk();
    cmp("irq raised", 32'h1, {31'h0, irq});
    bus(0, 6'h0c, 0); cmp("irq status", 32'h8, rdat & 32'h8);
    bus(1, 6'h10, 32'h0); @(negedge mclk); cmp("irq masked", 32'h0, {31'h0, irq});
    bus(1, 6'h10, 32'h8); @(negedge mclk); cmp("irq unmasked", 32'h1, {31'h0, irq});
    @(posedge mclk); warn <= 0;
    bus(1, 6'h14, 32'h8); @(negedge mclk); cmp("irq cleared", 32'h0, {31'h0, irq});
    bus(0, 6'h0c, 0); cmp("irq status clear", 32'h0, rdat & 32'h8);
    bus(0, 6'h14, 0); cmp("clear reads 0", 32'h0, rdat);
    give_verdict();
  end
endmodule
